/* src/itr_pkg.sv */
// Constants, types and register map of the two-wire target port
package itr_pkg;
  localparam logic [6:0] TGT_ADDR = 7'h50;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_CFG1 = 8'h60;
  localparam logic [7:0] REG_CFG2 = 8'h61;
  localparam logic [7:0] REG_EMASK = 8'h62;
  localparam logic [7:0] REG_TMO = 8'h6A;
  localparam logic [7:0] FORCE_CMD = 8'hFF;
  localparam logic [7:0] INVALID_BYTE = 8'hEE;
  localparam logic [15:0] CFG1_RST = 16'h740B;
  localparam logic [15:0] CFG2_RST = 16'h0000;
  localparam logic [15:0] EMASK_RST = 16'h001D;
  localparam logic [15:0] TMO_RST = 16'h00C8;
  localparam int CFG1_EVT_BIT = 6;
  localparam int CFG1_SA_BIT = 5;
  localparam int CFG2_ACK_BIT = 0;
  localparam int CFG2_SED_BIT = 1;
  localparam int FLG_RST_BIT = 7;
  localparam int EVT_W = 5;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYC = MS_PS / CLK_PERIOD_PS;
  localparam int FORCE_WAIT_MS = 2;
  localparam int FORCE_CYC = FORCE_WAIT_MS * MS_CYC;
  localparam int MAX_BIT_PS = 1000000;
  localparam int MIN_SAMPLES_PER_BIT = 16;

  typedef struct packed {
    logic power;
    logic ati;
    logic button;
    logic move;
    logic hall;
  } itr_evt_type;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_REG, S_RACK,
    S_WDAT, S_WACK, S_RDAT, S_MACK
  } itr_state_type;
endpackage

/* src/itr_target.sv */
// Two-wire target port with open-drain ready window line
`timescale 1ns/1ps
module itr_target
  import itr_pkg::*;
#(
  parameter int MS_CYC_P = MS_CYC,
  parameter int FORCE_CYC_P = FORCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic rdy_o,
  output logic rdy_oe,
  input wire logic cycle_tick,
  input wire itr_evt_type evt_src
);

  initial begin
    if (MAX_BIT_PS / CLK_PERIOD_PS < MIN_SAMPLES_PER_BIT) begin
      $error("clock too slow for 1 Mbit/s");
    end
    if (MS_CYC_P < 1 || FORCE_CYC_P < 1) begin
      $error("counts must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  logic scl_rise, scl_fall, start_p, stop_p;
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_p = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_p = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  ////////////////////////////////////////////////////////////////////////
  // Byte engine
  itr_state_type state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, rd_byte;
  logic rw_q, mack_q, oe_q;
  logic ld_p, wb_p, ra_p;

  assign ld_p = scl_fall & ((state_q == S_AACK & rw_q) |
                            (state_q == S_MACK & mack_q));
  assign wb_p = scl_fall & state_q == S_WDAT & cnt_q == 4'h8;
  assign ra_p = scl_fall & state_q == S_REG & cnt_q == 4'h8;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (stop_p) begin
      state_q <= S_IDLE;
      oe_q <= 1'b0;
    end else if (start_p) begin
      state_q <= S_ADDR;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (state_q == S_ADDR || state_q == S_REG || state_q == S_WDAT) begin
        sh_q <= {sh_q[6:0], sda_s2};
        cnt_q <= cnt_q + 4'h1;
      end
      if (state_q == S_MACK) begin
        mack_q <= ~sda_s2;
      end
    end else if (scl_fall) begin
      case (state_q)
        S_ADDR: begin
          if (cnt_q == 4'h8 && sh_q[7:1] == TGT_ADDR) begin
            state_q <= S_AACK;
            oe_q <= 1'b1;
            rw_q <= sh_q[0];
          end else if (cnt_q == 4'h8) begin
            state_q <= S_IDLE;
          end
        end
        S_AACK, S_MACK: begin
          if (ld_p) begin
            state_q <= S_RDAT;
            oe_q <= ~rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            cnt_q <= 4'h1;
          end else if (state_q == S_AACK) begin
            state_q <= S_REG;
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
          end else begin
            state_q <= S_IDLE;
            oe_q <= 1'b0;
          end
        end
        S_REG, S_WDAT: begin
          if (cnt_q == 4'h8) begin
            state_q <= (state_q == S_REG) ? S_RACK : S_WACK;
            oe_q <= 1'b1;
          end
        end
        S_RACK, S_WACK: begin
          state_q <= S_WDAT;
          oe_q <= 1'b0;
          cnt_q <= 4'h0;
        end
        S_RDAT: begin
          if (cnt_q == 4'h8) begin
            state_q <= S_MACK;
            oe_q <= 1'b0;
          end else begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign scl_o = 1'b0;
  // Read byte is muxed in one cycle, so the clock is never held
  assign scl_oe = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Register pointer and byte pairing
  logic [7:0] ptr_q, lo_q;
  logic hi_q, ww_p;
  logic [15:0] wr_data;
  assign ww_p = wb_p & hi_q;
  assign wr_data = {sh_q, lo_q};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
      hi_q <= 1'b0;
      lo_q <= 8'h00;
    end else if (ra_p) begin
      ptr_q <= sh_q;
      hi_q <= 1'b0;
    end else if (ld_p || wb_p) begin
      if (wb_p && !hi_q) begin
        lo_q <= sh_q;
      end
      hi_q <= ~hi_q;
      if (hi_q) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [15:0] cfg1_q, emask_q, tmo_q;
  logic sed_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q <= CFG1_RST;
      emask_q <= EMASK_RST;
      tmo_q <= TMO_RST;
      sed_q <= CFG2_RST[CFG2_SED_BIT];
    end else if (ww_p) begin
      case (ptr_q)
        REG_CFG1: cfg1_q <= wr_data;
        REG_CFG2: sed_q <= wr_data[CFG2_SED_BIT];
        REG_EMASK: emask_q <= wr_data;
        REG_TMO: tmo_q <= wr_data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag word
  logic show_rst_q, flg_clr;
  logic [EVT_W-1:0] evt_q, evt_in;
  logic [15:0] flags_w;
  assign evt_in = evt_src;
  assign flg_clr = ld_p & hi_q & ptr_q == REG_FLAGS;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      show_rst_q <= 1'b1;
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & {EVT_W{~flg_clr}}) | evt_in;
      if (ww_p && ptr_q == REG_CFG2 && wr_data[CFG2_ACK_BIT]) begin
        show_rst_q <= 1'b0;
      end
    end
  end

  always_comb begin
    flags_w = 16'h0000;
    flags_w[FLG_RST_BIT] = show_rst_q;
    flags_w[EVT_W-1:0] = evt_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  logic win_q;
  always_comb begin
    logic [15:0] w;
    logic ok;
    w = 16'h0000;
    ok = 1'b1;
    case (ptr_q)
      REG_FLAGS: w = flags_w;
      REG_CFG1: w = cfg1_q;
      REG_CFG2: w = {14'h0, sed_q, 1'b0};
      REG_EMASK: w = emask_q;
      REG_TMO: w = tmo_q;
      default: ok = 1'b0;
    endcase
    if (!win_q || !ok) begin
      rd_byte = INVALID_BYTE;
    end else begin
      rd_byte = hi_q ? w[15:8] : w[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Forced window request
  logic arm_q, frc_q, force_go;
  logic [$clog2(FORCE_CYC_P+1)-1:0] frc_cnt_q;
  assign force_go = frc_q &
    (frc_cnt_q == ($bits(frc_cnt_q))'(FORCE_CYC_P - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 1'b0;
      frc_q <= 1'b0;
      frc_cnt_q <= '0;
    end else begin
      if (ra_p) begin
        arm_q <= (sh_q == FORCE_CMD);
      end else if (wb_p || start_p || stop_p) begin
        arm_q <= 1'b0;
      end
      if (stop_p && arm_q) begin
        frc_q <= 1'b1;
        frc_cnt_q <= '0;
      end else if (force_go) begin
        frc_q <= 1'b0;
      end else if (frc_q) begin
        frc_cnt_q <= frc_cnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Window control and timeout
  logic stream, evt_mode, tick_open, open_w, close_w, to_hit, ms_p;
  logic [EVT_W-1:0] hits;
  logic [$clog2(MS_CYC_P+1)-1:0] ms_q;
  logic [15:0] to_q;

  assign stream = show_rst_q |
    ~(cfg1_q[CFG1_EVT_BIT] | cfg1_q[CFG1_SA_BIT]);
  assign evt_mode = ~show_rst_q & cfg1_q[CFG1_EVT_BIT] &
    ~cfg1_q[CFG1_SA_BIT];
  assign hits = (evt_in | evt_q) & emask_q[EVT_W-1:0];
  assign tick_open = cycle_tick & (stream | (evt_mode & |hits));
  assign open_w = tick_open | force_go;
  assign ms_p = ms_q == ($bits(ms_q))'(MS_CYC_P - 1);
  assign to_hit = win_q & (to_q >= tmo_q);
  assign close_w = (stop_p & ~sed_q) | to_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 1'b0;
    end else if (open_w) begin
      win_q <= 1'b1;
    end else if (close_w) begin
      win_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= '0;
      to_q <= 16'h0000;
    end else if (!win_q || open_w) begin
      ms_q <= '0;
      to_q <= 16'h0000;
    end else if (ms_p) begin
      ms_q <= '0;
      to_q <= to_q + 16'h0001;
    end else begin
      ms_q <= ms_q + 1'b1;
    end
  end

  assign rdy_o = 1'b0;
  assign rdy_oe = win_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_addr_match;
    scl_fall && state_q == S_ADDR && cnt_q == 4'h8 && sh_q[7:1] == TGT_ADDR;
  endsequence
  sequence s_ack_driven;
    sda_oe && state_q == S_AACK;
  endsequence

  chk_addr_ack: assert property (s_addr_match |=> s_ack_driven)
    else $error("address not acknowledged");
  chk_ptr_step: assert property (ld_p && hi_q |=>
    ptr_q == $past(ptr_q) + 8'h01 && !hi_q)
    else $error("pointer did not advance");
  chk_rdy_window: assert property (open_w |=> rdy_oe && !rdy_o)
    else $error("ready not pulled low");
  chk_stream_tick: assert property (cycle_tick && show_rst_q |=> win_q)
    else $error("streaming window missing");
  chk_sa_quiet: assert property (!force_go && cfg1_q[CFG1_SA_BIT] &&
    !show_rst_q && !win_q |=> !win_q)
    else $error("standalone window opened");
  chk_flag_clear: assert property (flg_clr && evt_in == '0 |=>
    evt_q == '0)
    else $error("flags not cleared");
  chk_timeout_close: assert property (to_hit && !open_w |=>
    !win_q && !rdy_oe)
    else $error("timeout did not close");
  chk_stop_close: assert property (stop_p && !sed_q && !open_w |=>
    !rdy_oe)
    else $error("stop did not close window");
  chk_stop_keep: assert property (stop_p && sed_q && win_q && !to_hit |=>
    win_q)
    else $error("stop closed window");
  chk_invalid_read: assert property (ld_p && !win_q |=>
    !sda_oe && tx_q == {INVALID_BYTE[6:0], 1'b0})
    else $error("invalid byte not sent");
  chk_force_open: assert property (force_go |=> win_q && rdy_oe)
    else $error("forced window late");
endmodule

/* tb/itr_host.sv */
// Bus master model for the two-wire target port
`timescale 1ns/1ps
module itr_host (
  output logic scl_m,
  output logic sda_m,
  input wire logic sda_w
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  task automatic q();
    #12;
  endtask

  // Start or repeated start
  task automatic start();
    q();
    sda_m = 1'b1;
    q();
    scl_m = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl_m = 1'b0;
  endtask

  task automatic stop();
    q();
    sda_m = 1'b0;
    q();
    scl_m = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask

  // One bit, data changed only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    q();
    sda_m = b;
    q();
    scl_m = 1'b1;
    q();
    r = sda_w;
    q();
    scl_m = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read is refused to end it
  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

/* tb/itr_target_tb.sv */
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
module itr_target_tb;
  import itr_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic cycle_tick;
  logic [4:0] evt_src;
  logic scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe, rdy_o, rdy_oe;
  wire scl_w = scl_m & ~scl_oe;
  wire sda_w = sda_m & ~sda_oe;
  int failures;
  int tests_run;
  int n;

  itr_target #(.MS_CYC_P(20), .FORCE_CYC_P(10)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .rdy_o(rdy_o), .rdy_oe(rdy_oe), .cycle_tick(cycle_tick),
    .evt_src(itr_evt_type'(evt_src))
  );
  itr_host u_host (.scl_m(scl_m), .sda_m(sda_m), .sda_w(sda_w));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input logic [4:0] e);
    @(posedge clk_sys);
    cycle_tick <= 1'b1;
    evt_src <= e;
    @(posedge clk_sys);
    cycle_tick <= 1'b0;
    evt_src <= 5'h00;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic wait_rdy(input logic exp, input int lim);
    n = 0;
    while (rdy_oe !== exp && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk_bit(rdy_oe, exp);
    if (rdy_oe !== exp) test_done();
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    u_host.wr_byte(d, a);
    chk_bit(a, exp_ack);
  endtask

  task automatic wreg(input logic [7:0] r, input logic [15:0] w);
    u_host.start();
    send(8'hA0, 1'b1);
    send(r, 1'b1);
    send(w[7:0], 1'b1);
    send(w[15:8], 1'b1);
    u_host.stop();
  endtask

  task automatic rd(input logic [7:0] r, input int nb, input logic [31:0] e);
    logic [7:0] b;
    u_host.start();
    send(8'hA0, 1'b1);
    send(r, 1'b1);
    u_host.start();
    send(8'hA1, 1'b1);
    for (int i = 0; i < nb; i++) begin
      u_host.rd_byte(b, i == nb - 1);
      chk_byte(b, e[8*i+:8]);
    end
    u_host.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    chk_bit(rdy_oe, 1'b0);
    chk_bit(scl_oe, 1'b0);
    chk_bit(scl_o, 1'b0);
    rd(REG_CFG1, 2, 32'h0000EEEE);
    u_host.start();
    send(8'hA2, 1'b0);
    u_host.stop();
    $display("test idle done");
  endtask

  task automatic t_stream();
    tick(5'h00);
    wait_rdy(1'b1, 4);
    chk_bit(rdy_o, 1'b0);
    chk_bit(sda_o, 1'b0);
    rd(REG_CFG1, 4, 32'h0000740B);
    wait_rdy(1'b0, 10);
    wreg(REG_EMASK, 16'h0004);
    tick(5'h00);
    wait_rdy(1'b1, 4);
    rd(REG_EMASK, 4, 32'hEEEE0004);
    wait_rdy(1'b0, 10);
    $display("test stream done");
  endtask

  task automatic t_event();
    wreg(REG_CFG2, 16'h0001);
    wreg(REG_CFG1, 16'h744B);
    tick(5'h00);
    chk_bit(rdy_oe, 1'b0);
    tick(5'h10);
    chk_bit(rdy_oe, 1'b0);
    tick(5'h04);
    wait_rdy(1'b1, 4);
    rd(REG_CFG1, 2, 32'h0000744B);
    wait_rdy(1'b0, 10);
    tick(5'h00);
    wait_rdy(1'b1, 4);
    rd(REG_FLAGS, 2, 32'h00000014);
    wait_rdy(1'b0, 10);
    tick(5'h00);
    chk_bit(rdy_oe, 1'b0);
    $display("test event done");
  endtask

  task automatic t_force();
    wreg(REG_CFG2, 16'h0002);
    u_host.start();
    send(8'hA0, 1'b1);
    send(FORCE_CMD, 1'b1);
    u_host.stop();
    wait_rdy(1'b1, 40);
    rd(REG_CFG2, 2, 32'h00000002);
    repeat (10) @(posedge clk_sys);
    chk_bit(rdy_oe, 1'b1);
    wreg(REG_CFG2, 16'h0000);
    wait_rdy(1'b0, 10);
    wreg(REG_CFG1, 16'h742B);
    tick(5'h04);
    chk_bit(rdy_oe, 1'b0);
    u_host.start();
    send(8'hA0, 1'b1);
    send(FORCE_CMD, 1'b1);
    u_host.stop();
    wait_rdy(1'b1, 40);
    wait_rdy(1'b0, 4100);
    chk_bit(n >= 3990, 1'b1);
    $display("test force done");
  endtask

  initial begin
    failures = 0;
    tests_run = 0;
    rst_n = 1'b0;
    cycle_tick = 1'b0;
    evt_src = 5'h00;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_idle();
    t_stream();
    t_event();
    t_force();
    test_done();
  end
endmodule
